// file: logic/ioadw_core.sv
/*
  ioadw_core: diagnostic wrap and adapter-directed command handling.
  assumes: one command per cmd_valid pulse, answered in the next cycle;
  parity check result and device data arrive with the command.
*/
// Behaviour
// - wrap 00 local raises zero-info attention
// - attention clears when serviced; reissue for more
// - wrap 01 write copies data to capture
// - write parity error: cc5, capture unchanged
// - wrap 01/11 read returns and loads zeros
// - read parity error: cc5, capture unchanged
// - wrap 10 capture format zero/func/mod/addr
// - function/modifier lines equal command bits 1-7
// - wrap 10 write captures control lines
// - wrap 10 read returns zeros, captures lines
// - wrap 11 write loads data AND lines
// - bit16 set enters external mode, passes commands
// - external bit30 resets devices, bit31 modifier
// - reset-diag clears mode and capture, parity checked
// - reset-diag outside diagnostic mode leaves mode and capture alone
// - status word read clears parity bits
// - other successful commands clear parity bits
// - read diag data returns capture, no clear
// - read diag outside diagnostic mode returns zeros
// - read-id returns device plus adapter id
// - set-diag enters mode and clears capture
// - local mode masks devices, forces parity zero
// - resets clear mode, capture and status
`timescale 1ns/1ps
`default_nettype none
module ioadw_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sys_reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] dev_addr,
  input wire logic [15:0] imm_data,
  input wire logic parity_err,
  input wire logic out_par_event,
  input wire logic in_par_event,
  input wire logic [15:0] dev_data,
  input wire logic [7:0] dev_id,
  input wire logic dev_irq,
  input wire logic attn_taken,
  input wire logic [3:0] addr_jumpers,
  output logic rsp_valid,
  output logic [2:0] rsp_cc,
  output logic [15:0] rsp_data,
  output logic attn_req,
  output logic [7:0] interrupt_info_byte,
  output logic [7:0] attn_addr,
  output logic dev_irq_out,
  output logic dev_cmd_valid,
  output logic [6:0] dev_func_mod,
  output logic [3:0] dev_addr_lines,
  output logic [15:0] dev_wdata,
  output logic dev_reset,
  output logic diag_modifier,
  output logic [15:0] diagnostic_capture
);
  ioadw_pkg::ioadw_mode_e mode_r;
  logic [1:0] wsel_r;
  logic [15:0] stat_r;
  logic [15:0] lines;
  logic is_dev, is_wr, is_rd, ok, in_diag;

  function automatic logic dev_directed(input logic [7:0] c);
    dev_directed = (c[7:4] != 4'h6 && c[7:4] != 4'h2) || (c[7:4] == 4'h2
      && c != ioadw_pkg::CMD_RD_STATUS_WORD && c != ioadw_pkg::CMD_RD_DIAG)
      || (c[7:4] == 4'h6 && c[3:0] > 4'h2);
  endfunction

  assign is_dev = cmd_valid && dev_directed(cmd_code);
  assign is_wr = cmd_code[6];
  assign is_rd = !cmd_code[6];
  assign ok = !parity_err;
  assign in_diag = mode_r != ioadw_pkg::IOADW_OFF;
  // zeros 16-20, function 21-24, modifier 25-27, address 28-31
  assign lines = {5'h00, cmd_code[6:0], dev_addr[3:0]};

  // mode and wrap select persist until a command or reset changes them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= ioadw_pkg::IOADW_OFF;
      wsel_r <= ioadw_pkg::WRAP_ATTN;
    end
    else if (clk_en)
    begin
      if (sys_reset)
      begin
        mode_r <= ioadw_pkg::IOADW_OFF;
        wsel_r <= ioadw_pkg::WRAP_ATTN;
      end
      else if (cmd_valid && ok && cmd_code == ioadw_pkg::CMD_SET_DIAG)
      begin
        mode_r <= imm_data[ioadw_pkg::EXT_BIT] ? ioadw_pkg::IOADW_EXT
          : ioadw_pkg::IOADW_LOCAL;
        wsel_r <= imm_data[ioadw_pkg::WSEL_HI:ioadw_pkg::WSEL_LO];
      end
      else if (cmd_valid && ok && cmd_code == ioadw_pkg::CMD_RESET_DIAG && in_diag)
      begin
        mode_r <= ioadw_pkg::IOADW_OFF;
        wsel_r <= ioadw_pkg::WRAP_ATTN;
      end
    end
  end

  // capture register; a parity error leaves it untouched
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      diagnostic_capture <= ioadw_pkg::DIAG_RESET;
    else if (clk_en)
    begin
      if (sys_reset)
        diagnostic_capture <= ioadw_pkg::DIAG_RESET;
      else if (cmd_valid && ok && cmd_code == ioadw_pkg::CMD_SET_DIAG)
        diagnostic_capture <= ioadw_pkg::DIAG_RESET;
      else if (cmd_valid && ok && cmd_code == ioadw_pkg::CMD_RESET_DIAG && in_diag)
        diagnostic_capture <= ioadw_pkg::DIAG_RESET;
      else if (is_dev && ok && mode_r == ioadw_pkg::IOADW_EXT && is_rd)
        diagnostic_capture <= dev_data;
      else if (is_dev && ok && mode_r == ioadw_pkg::IOADW_LOCAL)
      begin
        unique case (wsel_r)
          ioadw_pkg::WRAP_DATA:
            diagnostic_capture <= is_wr ? imm_data : 16'h0000;
          ioadw_pkg::WRAP_LINES:
            diagnostic_capture <= lines;
          ioadw_pkg::WRAP_AND:
            diagnostic_capture <= is_wr ? (imm_data & lines) : 16'h0000;
          ioadw_pkg::WRAP_ATTN:
            diagnostic_capture <= diagnostic_capture;
        endcase
      end
    end
  end

  // status word: parity bits set by events, set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_r <= ioadw_pkg::STAT_RESET;
    else if (clk_en)
    begin
      if (sys_reset)
        stat_r <= ioadw_pkg::STAT_RESET;
      else if (mode_r == ioadw_pkg::IOADW_LOCAL)
        stat_r <= ioadw_pkg::STAT_RESET;
      else
      begin
        if (cmd_valid && ok)
        begin
          stat_r[ioadw_pkg::STAT_OUT_PAR] <= 1'b0;
          stat_r[ioadw_pkg::STAT_IN_PAR] <= 1'b0;
        end
        if (out_par_event)
          stat_r[ioadw_pkg::STAT_OUT_PAR] <= 1'b1;
        if (in_par_event)
          stat_r[ioadw_pkg::STAT_IN_PAR] <= 1'b1;
      end
    end
  end

  // attention request from set-diag wrap 00 in local mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      attn_req <= 1'b0;
      interrupt_info_byte <= 8'h00;
      attn_addr <= 8'h00;
    end
    else if (clk_en)
    begin
      interrupt_info_byte <= 8'h00;
      attn_addr <= {addr_jumpers, 4'h0};
      if (sys_reset)
        attn_req <= 1'b0;
      else if (cmd_valid && ok && cmd_code == ioadw_pkg::CMD_SET_DIAG
               && !imm_data[ioadw_pkg::EXT_BIT]
               && imm_data[ioadw_pkg::WSEL_HI:ioadw_pkg::WSEL_LO] == ioadw_pkg::WRAP_ATTN)
        attn_req <= 1'b1;
      else if (attn_taken)
        attn_req <= 1'b0;
    end
  end

  // command answer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_cc <= ioadw_pkg::CC_OK;
      rsp_data <= 16'h0000;
    end
    else if (clk_en)
    begin
      rsp_valid <= cmd_valid;
      if (cmd_valid)
      begin
        rsp_cc <= parity_err ? ioadw_pkg::CC_DATA_CHECK : ioadw_pkg::CC_OK;
        if (cmd_code == ioadw_pkg::CMD_RD_STATUS_WORD)
          rsp_data <= stat_r;
        else if (cmd_code == ioadw_pkg::CMD_RD_DIAG)
          rsp_data <= in_diag ? diagnostic_capture : 16'h0000;
        // local mode answers device reads itself, so the id word is not fetched there
        else if (cmd_code == ioadw_pkg::CMD_READ_ID && mode_r != ioadw_pkg::IOADW_LOCAL)
          rsp_data <= {dev_id, ioadw_pkg::ADAPTER_ID};
        else if (is_dev && is_rd && mode_r == ioadw_pkg::IOADW_LOCAL)
          rsp_data <= 16'h0000;
        else if (is_dev && is_rd)
          rsp_data <= dev_data;
        else
          rsp_data <= 16'h0000;
      end
    end
  end

  // device-side lines; held inactive in local mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_cmd_valid <= 1'b0;
      dev_func_mod <= 7'h00;
      dev_addr_lines <= 4'h0;
      dev_wdata <= 16'h0000;
      dev_reset <= 1'b0;
      diag_modifier <= 1'b0;
      dev_irq_out <= 1'b0;
    end
    else if (clk_en)
    begin
      dev_cmd_valid <= is_dev && ok && mode_r != ioadw_pkg::IOADW_LOCAL;
      if (is_dev && ok && mode_r != ioadw_pkg::IOADW_LOCAL)
      begin
        dev_func_mod <= cmd_code[6:0];
        dev_addr_lines <= dev_addr[3:0];
        dev_wdata <= imm_data;
      end
      dev_irq_out <= dev_irq && mode_r != ioadw_pkg::IOADW_LOCAL;
      dev_reset <= cmd_valid && ok && cmd_code == ioadw_pkg::CMD_SET_DIAG
        && imm_data[ioadw_pkg::EXT_BIT] && imm_data[ioadw_pkg::WSEL_HI];
      // set-diag is tested before the off check, as mode_r still reads off on that edge
      if (sys_reset)
        diag_modifier <= 1'b0;
      else if (cmd_valid && ok && cmd_code == ioadw_pkg::CMD_SET_DIAG)
        diag_modifier <= imm_data[ioadw_pkg::EXT_BIT] && imm_data[ioadw_pkg::WSEL_LO];
      else if (mode_r == ioadw_pkg::IOADW_OFF)
        diag_modifier <= 1'b0;
    end
  end

  // checks
  AST_WRITE_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !sys_reset && is_dev && ok && is_wr && mode_r == ioadw_pkg::IOADW_LOCAL
    && wsel_r == ioadw_pkg::WRAP_DATA |=> diagnostic_capture == $past(imm_data))
    else $error("wrap 01 write not captured");
  AST_PARITY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !sys_reset && cmd_valid && parity_err |=> $stable(diagnostic_capture))
    else $error("capture changed on parity error");
  AST_PARITY_CC: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cmd_valid && parity_err |=> rsp_valid && rsp_cc == ioadw_pkg::CC_DATA_CHECK)
    else $error("missing cc5");
  AST_AND_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !sys_reset && is_dev && ok && is_wr && mode_r == ioadw_pkg::IOADW_LOCAL
    && wsel_r == ioadw_pkg::WRAP_AND |=> diagnostic_capture == $past(imm_data & lines))
    else $error("wrap 11 and wrong");
  AST_LINES_FMT: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !sys_reset && is_dev && ok && mode_r == ioadw_pkg::IOADW_LOCAL
    && wsel_r == ioadw_pkg::WRAP_LINES
    |=> diagnostic_capture == $past({5'h00, cmd_code[6:0], dev_addr[3:0]}))
    else $error("wrap 10 capture format wrong");
  AST_ATTN_SET: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !sys_reset && cmd_valid && ok && cmd_code == ioadw_pkg::CMD_SET_DIAG
    && imm_data[15] == 1'b0 && imm_data[1:0] == 2'h0 |=> attn_req)
    else $error("attention not raised");
  AST_DIAG_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cmd_valid && cmd_code == ioadw_pkg::CMD_RD_DIAG && !in_diag
    |=> rsp_data == 16'h0000)
    else $error("read diag outside mode not zero");
  AST_LOCAL_PAR: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && mode_r == ioadw_pkg::IOADW_LOCAL && !sys_reset |=> stat_r == 16'h0000)
    else $error("parity bits not forced in local mode");
  // service without a fresh set-diag in the same cycle
  sequence attn_service_s;
    clk_en && !sys_reset && attn_taken
    && !(cmd_valid && ok && cmd_code == ioadw_pkg::CMD_SET_DIAG);
  endsequence
  AST_ATTN_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    attn_service_s |=> !attn_req)
    else $error("attention not cleared after service");
  AST_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !sys_reset && is_dev && ok && is_rd && mode_r == ioadw_pkg::IOADW_LOCAL
    && wsel_r == ioadw_pkg::WRAP_DATA
    |=> diagnostic_capture == 16'h0000 && rsp_data == 16'h0000)
    else $error("wrap 01 read not zero");
endmodule
`default_nettype wire

// file: logic/ioadw_pkg.sv
/*
  ioadw_pkg: constants for the diagnostic wrap logic of the programmed-I/O adapter.
  assumes: nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ioadw_pkg;
  // command field codes
  localparam logic [7:0] CMD_READ_ID = 8'h20;
  localparam logic [7:0] CMD_RD_STATUS_WORD = 8'h2e;
  localparam logic [7:0] CMD_RD_DIAG = 8'h2f;
  localparam logic [7:0] CMD_PREPARE = 8'h60;
  localparam logic [7:0] CMD_SET_DIAG = 8'h61;
  localparam logic [7:0] CMD_RESET_DIAG = 8'h62;
  // condition codes
  localparam logic [2:0] CC_DATA_CHECK = 3'h5;
  localparam logic [2:0] CC_OK = 3'h7;
  // wrap select values (data bits 30,31)
  localparam logic [1:0] WRAP_ATTN = 2'h0;
  localparam logic [1:0] WRAP_DATA = 2'h1;
  localparam logic [1:0] WRAP_LINES = 2'h2;
  localparam logic [1:0] WRAP_AND = 2'h3;
  // field positions in the 16-bit data word (bit 16 of the block is index 15)
  localparam int EXT_BIT = 15;
  localparam int WSEL_HI = 1;
  localparam int WSEL_LO = 0;
  // status word layout: parity error bits
  localparam int STAT_OUT_PAR = 1;
  localparam int STAT_IN_PAR = 0;
  // reset values
  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  // adapter part of the identification word; arbitrary value
  localparam logic [7:0] ADAPTER_ID = 8'h5a;
  typedef enum logic [2:0] {
    IOADW_OFF = 3'b001,
    IOADW_LOCAL = 3'b010,
    IOADW_EXT = 3'b100
  } ioadw_mode_e;
endpackage
`default_nettype wire

// file: dv/ioadw_chan.sv
/*
  ioadw_chan: channel model that issues control blocks and services attention.
  assumes: clk comes from the bench; outputs change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ioadw_chan (
  input wire logic clk,
  input wire logic attn_req,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [7:0] dev_addr,
  output logic [15:0] imm_data,
  output logic parity_err,
  output logic attn_taken
);
  int svc_wait = 3;
  int cnt = 0;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    dev_addr = 8'h00;
    imm_data = 16'h0000;
    parity_err = 1'b0;
    attn_taken = 1'b0;
  end
  // slow service so the request is seen to stand before it clears
  always @(posedge clk)
  begin
    attn_taken <= 1'b0;
    if (!attn_req)
      cnt <= 0;
    else if (cnt == svc_wait)
    begin
      attn_taken <= 1'b1;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
  task automatic issue(input logic [7:0] c, input logic [7:0] a, input logic [15:0] d,
    input logic p);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    dev_addr <= a;
    imm_data <= d;
    parity_err <= p;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // released fields go inverse so a stale value never looks live
    cmd_code <= ~c;
    dev_addr <= ~a;
    imm_data <= ~d;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/*
  tb_top: self-checking bench for ioadw_core against a reference model.
  assumes: ioadw_pkg, ioadw_core and ioadw_chan are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_n, clk_en, sys_reset, out_par_event, in_par_event, dev_irq;
  logic cmd_valid, parity_err, attn_taken, rsp_valid, attn_req, dev_irq_out;
  logic dev_cmd_valid, dev_reset, diag_modifier;
  logic [7:0] cmd_code, dev_addr, dev_id, interrupt_info_byte, attn_addr;
  logic [15:0] imm_data, dev_data, rsp_data, dev_wdata, diagnostic_capture, cap, st;
  logic [3:0] addr_jumpers, dev_addr_lines;
  logic [2:0] rsp_cc;
  logic [6:0] dev_func_mod;
  int md, ws, seed, n_fail, total_checks, cyc;
  logic [7:0] codes [12] = '{8'h05, 8'h15, 8'h20, 8'h27, 8'h2e, 8'h2f, 8'h45, 8'h55,
    8'h60, 8'h61, 8'h62, 8'h6a};
  ioadw_core u_ioadw_core (.clk, .rst_n, .clk_en, .sys_reset, .cmd_valid, .cmd_code,
    .dev_addr, .imm_data, .parity_err, .out_par_event, .in_par_event, .dev_data, .dev_id,
    .dev_irq, .attn_taken, .addr_jumpers, .rsp_valid, .rsp_cc, .rsp_data, .attn_req,
    .interrupt_info_byte, .attn_addr, .dev_irq_out, .dev_cmd_valid, .dev_func_mod,
    .dev_addr_lines, .dev_wdata, .dev_reset, .diag_modifier, .diagnostic_capture);
  ioadw_chan u_ioadw_chan (.clk, .attn_req, .cmd_valid, .cmd_code, .dev_addr,
    .imm_data, .parity_err, .attn_taken);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ev(input logic o, input logic i);
    @(posedge clk);
    out_par_event <= o;
    in_par_event <= i;
    @(posedge clk);
    out_par_event <= 1'b0;
    in_par_event <= 1'b0;
    st = st | {14'h0000, o, i};
  endtask
  // model first, then one command, then compare the answer, device lines and capture
  task automatic run(input logic [7:0] c, input logic [15:0] d, input logic p);
    logic [7:0] a;
    logic [15:0] dd, er, ln;
    logic dir, kr;
    a = 8'($random(seed));
    dd = 16'($random(seed));
    ln = {5'h00, c[6:0], a[3:0]};
    dir = !(c inside {8'h2e, 8'h2f, 8'h60, 8'h61, 8'h62});
    kr = !p && (c == 8'h2e || c == 8'h2f || (dir && !c[6] && (md != 1 || ws != 0)));
    er = 16'h0000;
    if (c == 8'h2e && md != 1) er = st;
    if (c == 8'h2f && md != 0) er = cap;
    if (dir && !c[6] && md != 1) er = (c == 8'h20) ? {dev_id, ioadw_pkg::ADAPTER_ID} : dd;
    @(posedge clk);
    dev_data <= dd;
    u_ioadw_chan.issue(c, a, d, p);
    #1;
    chk(rsp_valid, 1'b1);
    chk(rsp_cc, p ? 3'h5 : 3'h7);
    if (kr) chk(rsp_data, er);
    if (dir && !p) chk(dev_cmd_valid, md != 1);
    if (dir && !p && md != 1) chk(dev_func_mod, c[6:0]);
    if (dir && !p && md != 1) chk(dev_addr_lines, a[3:0]);
    if (dir && !p && md != 1) chk(dev_wdata, d);
    if (!p)
    begin
      if (md == 1 && dir && ws == 1) cap = c[6] ? d : 16'h0000;
      if (md == 1 && dir && ws == 2) cap = ln;
      if (md == 1 && dir && ws == 3) cap = c[6] ? (d & ln) : 16'h0000;
      if (md == 2 && dir && !c[6]) cap = dd;
      if (c == 8'h62 || c == 8'h61) cap = 16'h0000;
      if (c == 8'h62) md = 0;
      if (c == 8'h61) md = d[15] ? 2 : 1;
      if (c == 8'h61) ws = d[1:0];
      if (c == 8'h61) chk(dev_reset, d[15] & d[1]);
      if (c == 8'h61 && d[15]) chk(diag_modifier, d[0]);
      st = 16'h0000;
    end
    chk(diagnostic_capture, cap);
  endtask
  initial
  begin
    logic [15:0] d;
    seed = 26;
    clk_en = 1'b1;
    rst_n = 1'b0;
    sys_reset = 1'b0;
    out_par_event = 1'b0;
    in_par_event = 1'b0;
    dev_irq = 1'b0;
    dev_data = 16'h0000;
    dev_id = 8'($random(seed));
    addr_jumpers = 4'($random(seed));
    cap = 16'h0000;
    st = 16'h0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(diagnostic_capture, 16'h0000);
    chk(rsp_cc, 3'h7);
    ev(1'b1, 1'b0);
    run(8'h2e, 16'h0000, 1'b0);
    run(8'h2e, 16'h0000, 1'b0);
    ev(1'b0, 1'b1);
    run(8'h60, 16'h0000, 1'b1);
    run(8'h2e, 16'h0000, 1'b0);
    ev(1'b1, 1'b1);
    run(8'h45, 16'h0000, 1'b0);
    run(8'h2e, 16'h0000, 1'b0);
    run(8'h61, 16'h0000, 1'b0);
    chk(attn_req, 1'b1);
    chk(attn_addr, {addr_jumpers, 4'h0});
    chk(interrupt_info_byte, 8'h00);
    @(posedge clk);
    dev_irq <= 1'b1;
    for (int i = 0; i < 20 && attn_req; i++) @(posedge clk);
    @(posedge clk);
    #1;
    chk(attn_req, 1'b0);
    chk(dev_irq_out, 1'b0);
    run(8'h61, 16'h0000, 1'b0);
    chk(attn_req, 1'b1);
    run(8'h62, 16'h0000, 1'b0);
    run(8'h62, 16'h0000, 1'b0);
    chk(dev_irq_out, 1'b1);
    repeat (300)
    begin
      d = 16'($random(seed));
      if (!d[15] && d[1:0] == 2'h0) d[0] = 1'b1;
      run(codes[$unsigned($random(seed)) % 12], d, ($random(seed) & 7) == 0);
    end
    run(8'h61, 16'h0001, 1'b0);
    run(8'h45, 16'h1234, 1'b0);
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
    md = 0;
    cap = 16'h0000;
    run(8'h2f, 16'h0000, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
